// ---- src/lmr_regs.svh ----
// Purpose: constants for the local memory region control block
// Assumes: included by the design modules and the bench modules
// Notes:   coprocessor selector values, field positions, map and reset values
//
// Overview of operation
// [R01] Instruction window 0000-5FFF: bank0, bank1, ROM of 8K each; 6000-7FFF reserved.
// [R02] Data window 8000-DFFF: bank0, bank1, ROM of 8K each; E000-FFFF reserved.
// [R03] Presence read: bit 16 data memory present, bit 0 instruction present, rest zero.
// [R04] Presence register is register 0, secondary c0, opcode2 2, read only.
// [R05] Setup register bits 31-12 hold base; physical base is field shifted left 12.
// [R06] Setup bits 11-6 read zero and bit 1 always reads zero.
// [R07] Size field bits 5-2: 0000 absent, 0011..1011 are 4 kB..1 MB.
// [R08] Setup bit 0 enables the memory; reads return the written enable.
// [R09] Data setup is register 9, c1, opcode2 0; instruction setup uses opcode2 1.
// [R10] Instruction size field reads fixed 5h (16 kB); writes to it ignored.
// [R11] Data size field reads fixed 6h (32 kB); writes to it ignored.
// [R12] Software programs instruction base 00000h and data base 00008h.
// [R13] Transfers are accepted only from the core in a privileged mode.
// [R14] Reset clears both enable bits so neither memory responds.
// [R15] A bank is selected only when enabled and inside a RAM or ROM region.
`ifndef LMR_REGS_SVH
`define LMR_REGS_SVH

// Coprocessor selectors
`define LMR_OP1_SYS       3'h0
`define LMR_CRN_PRESENCE  4'h0
`define LMR_CRM_PRESENCE  4'h0
`define LMR_OP2_PRESENCE  3'h2
`define LMR_CRN_REGION    4'h9
`define LMR_CRM_REGION    4'h1
`define LMR_OP2_DATA      3'h0
`define LMR_OP2_INSTR     3'h1

// Presence register fields
`define LMR_PRES_DATA_BIT   16
`define LMR_PRES_INSTR_BIT  0
`define LMR_DATA_PRESENT    1'h1
`define LMR_INSTR_PRESENT   1'h1

// Region setup register fields
`define LMR_BASE_MSB   31
`define LMR_BASE_LSB   12
`define LMR_SIZE_MSB   5
`define LMR_SIZE_LSB   2
`define LMR_EN_BIT     0
`define LMR_RSVD_W     6
`define LMR_SIZE_ABSENT 4'h0
`define LMR_SIZE_4K     4'h3
`define LMR_SIZE_1M     4'hB
`define LMR_INSTR_SIZE  4'h5
`define LMR_DATA_SIZE   4'h6

// Reset values and expected programmed bases
`define LMR_BASE_RESET  20'h00000
`define LMR_EN_RESET    1'h0
`define LMR_INSTR_BASE_EXPECT 20'h00000
`define LMR_DATA_BASE_EXPECT  20'h00008

// Fixed local memory map: bits 31-15 pick the window, 14-13 the 8K region
`define LMR_WIN_INSTR   17'h00000
`define LMR_WIN_DATA    17'h00001
`define LMR_REG_RAM0    2'h0
`define LMR_REG_RAM1    2'h1
`define LMR_REG_ROM     2'h2
`define LMR_REG_RSVD    2'h3

`endif

// ---- src/lmr_pkg.sv ----
// Purpose: types shared by the local memory region control modules
// Assumes: constants come from lmr_regs.svh
// Notes:   one-hot transfer states
package lmr_pkg;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        priv;
        logic [2:0]  op1;
        logic [3:0]  crn;
        logic [3:0]  crm;
        logic [2:0]  op2;
        logic [31:0] wdata;
    } cp_req_t;

    typedef struct packed {
        logic ram0;
        logic ram1;
        logic rom;
    } bank_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } xfer_state_t;

endpackage : lmr_pkg

// ---- src/region_decode.sv ----
// Purpose: decode one side's address into a RAM bank or ROM select
// Assumes: address and valid come from logic on clk_sys
// Notes:   select is registered, one cycle after the address
`include "lmr_regs.svh"
module region_decode
    import lmr_pkg::*;
#(
    parameter logic [16:0] WINDOW = 17'h00000
)(
    // Clock and reset
    input  wire logic      clk_sys,
    input  wire logic      rst,
    // Access
    input  wire logic      acc_valid,
    input  wire logic [31:0] acc_addr,
    input  wire logic      region_enable,
    // Select
    output bank_sel_t      sel
);

    bank_sel_t next_sel;

    always_comb
    begin
        next_sel = '0;
        if (acc_valid && region_enable && acc_addr[31:15] == WINDOW) // [R15]
        begin
            case (acc_addr[14:13])
                `LMR_REG_RAM0: next_sel.ram0 = 1'b1; // [R01] [R02]
                `LMR_REG_RAM1: next_sel.ram1 = 1'b1;
                `LMR_REG_ROM:  next_sel.rom  = 1'b1;
                default:       next_sel      = '0;   // Reserved 8K: no bank
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            sel <= '0;
        else
            sel <= next_sel;
    end

    a_sel_onehot: assert property (@(posedge clk_sys) disable iff (rst)
        $onehot0(sel)) // [R15]
        else $error("more than one bank selected");

    a_rsvd_nosel: assert property (@(posedge clk_sys) disable iff (rst)
        acc_valid && acc_addr[14:13] == `LMR_REG_RSVD |=> sel == '0) // [R15]
        else $error("reserved region selected a bank");

endmodule : region_decode

// ---- src/local_memory_region_control.sv ----
// Purpose: system control coprocessor registers for the two local memories
// Assumes: core drives one transfer at a time on clk_sys
// Notes:   answer one cycle after a request is taken; bank selects registered
`include "lmr_regs.svh"
module local_memory_region_control
    import lmr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Coprocessor transfer port
    input  cp_req_t          cp_req,
    output logic [31:0]      cp_rdata,
    output logic             cp_ack,
    output logic             cp_undef,
    // Instruction side access
    input  wire logic        instr_acc_valid,
    input  wire logic [31:0] instr_acc_addr,
    output bank_sel_t        instr_side_local_mem_sel,
    // Data side access
    input  wire logic        data_acc_valid,
    input  wire logic [31:0] data_acc_addr,
    output bank_sel_t        data_side_local_mem_sel,
    // Region state
    output logic             instr_region_enable,
    output logic             data_region_enable,
    output logic [31:0]      instr_local_mem_base,
    output logic [31:0]      data_local_mem_base
);

    ////////////////////////////////////////////////////////////////////////
    // Request decode

    logic hit_presence;
    logic hit_data;
    logic hit_instr;
    logic mapped;
    logic allowed;

    always_comb
    begin
        hit_presence = cp_req.op1 == `LMR_OP1_SYS
                    && cp_req.crn == `LMR_CRN_PRESENCE
                    && cp_req.crm == `LMR_CRM_PRESENCE
                    && cp_req.op2 == `LMR_OP2_PRESENCE
                    && !cp_req.write; // [R04]
        hit_data     = cp_req.op1 == `LMR_OP1_SYS
                    && cp_req.crn == `LMR_CRN_REGION
                    && cp_req.crm == `LMR_CRM_REGION
                    && cp_req.op2 == `LMR_OP2_DATA; // [R09]
        hit_instr    = cp_req.op1 == `LMR_OP1_SYS
                    && cp_req.crn == `LMR_CRN_REGION
                    && cp_req.crm == `LMR_CRM_REGION
                    && cp_req.op2 == `LMR_OP2_INSTR; // [R09]
        mapped       = hit_presence || hit_data || hit_instr;
        // User mode never reaches these registers
        allowed      = mapped && cp_req.priv; // [R13]
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencing

    xfer_state_t state;
    xfer_state_t next_state;
    logic        take;

    always_comb
    begin
        take = 1'b0;
        case (state)
            ST_IDLE:
            begin
                take       = cp_req.valid;
                next_state = cp_req.valid ? ST_RESP : ST_IDLE;
            end
            ST_RESP: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // Region setup registers

    logic [19:0] data_base;
    logic [19:0] instr_base;
    logic        data_en;
    logic        instr_en;
    logic [19:0] next_data_base;
    logic [19:0] next_instr_base;
    logic        next_data_en;
    logic        next_instr_en;
    logic        wr_ok;

    always_comb
    begin
        wr_ok           = take && allowed && cp_req.write;
        next_data_base  = data_base;
        next_instr_base = instr_base;
        next_data_en    = data_en;
        next_instr_en   = instr_en;
        // Size, reserved and bit 1 are not stored: writes there vanish
        if (wr_ok && hit_data)
        begin
            next_data_base = cp_req.wdata[`LMR_BASE_MSB:`LMR_BASE_LSB]; // [R05]
            next_data_en   = cp_req.wdata[`LMR_EN_BIT]; // [R08] [R11]
        end
        if (wr_ok && hit_instr)
        begin
            next_instr_base = cp_req.wdata[`LMR_BASE_MSB:`LMR_BASE_LSB]; // [R05]
            next_instr_en   = cp_req.wdata[`LMR_EN_BIT]; // [R08] [R10]
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            data_base  <= `LMR_BASE_RESET;
            instr_base <= `LMR_BASE_RESET;
            data_en    <= `LMR_EN_RESET; // [R14]
            instr_en   <= `LMR_EN_RESET; // [R14]
        end
        else
        begin
            data_base  <= next_data_base;
            instr_base <= next_instr_base;
            data_en    <= next_data_en;
            instr_en   <= next_instr_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and answer

    logic [31:0] presence_word;
    logic [31:0] data_word;
    logic [31:0] instr_word;
    logic [31:0] next_rdata;
    logic        next_ack;
    logic        next_undef;

    always_comb
    begin
        presence_word = 32'h0000_0000;
        presence_word[`LMR_PRES_DATA_BIT]  = `LMR_DATA_PRESENT; // [R03]
        presence_word[`LMR_PRES_INSTR_BIT] = `LMR_INSTR_PRESENT; // [R03]
        // Reserved bits and bit 1 are constant zero
        data_word  = {data_base, {`LMR_RSVD_W{1'b0}}, `LMR_DATA_SIZE, 1'b0,
                      data_en}; // [R06] [R11]
        instr_word = {instr_base, {`LMR_RSVD_W{1'b0}}, `LMR_INSTR_SIZE, 1'b0,
                      instr_en}; // [R06] [R10]
        next_rdata = 32'h0000_0000;
        next_ack   = 1'b0;
        next_undef = 1'b0;
        if (take)
        begin
            next_ack   = allowed;
            next_undef = !allowed; // [R13]
            if (allowed && !cp_req.write)
            begin
                if (hit_presence)
                    next_rdata = presence_word;
                else if (hit_data)
                    next_rdata = data_word;
                else
                    next_rdata = instr_word;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cp_rdata <= 32'h0000_0000;
            cp_ack   <= 1'b0;
            cp_undef <= 1'b0;
        end
        else
        begin
            cp_rdata <= next_rdata;
            cp_ack   <= next_ack;
            cp_undef <= next_undef;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Region state outputs

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            instr_region_enable  <= 1'b0;
            data_region_enable   <= 1'b0;
            instr_local_mem_base <= 32'h0000_0000;
            data_local_mem_base  <= 32'h0000_0000;
        end
        else
        begin
            instr_region_enable  <= next_instr_en;
            data_region_enable   <= next_data_en;
            instr_local_mem_base <= {next_instr_base, 12'h000}; // [R05]
            data_local_mem_base  <= {next_data_base, 12'h000}; // [R05]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bank decode; the map is fixed, the base field only reports placement

    region_decode #(
        .WINDOW (`LMR_WIN_INSTR)
    ) u_instr_decode (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .acc_valid     (instr_acc_valid),
        .acc_addr      (instr_acc_addr),
        .region_enable (instr_en), // [R01] [R15]
        .sel           (instr_side_local_mem_sel)
    );

    region_decode #(
        .WINDOW (`LMR_WIN_DATA)
    ) u_data_decode (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .acc_valid     (data_acc_valid),
        .acc_addr      (data_acc_addr),
        .region_enable (data_en), // [R02] [R15]
        .sel           (data_side_local_mem_sel)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_presence_read: assert property (@(posedge clk_sys) disable iff (rst) // [R03]
        state == ST_IDLE && cp_req.valid && cp_req.priv && hit_presence
        |=> cp_ack && cp_rdata == 32'h0001_0001)
        else $error("presence read returned wrong word");

    a_fixed_fields: assert property (@(posedge clk_sys) disable iff (rst) // [R06]
        cp_ack |-> cp_rdata[11:6] == 6'h00 && cp_rdata[1] == 1'b0)
        else $error("reserved bits of read data not zero");

    a_instr_size: assert property (@(posedge clk_sys) disable iff (rst) // [R10]
        state == ST_IDLE && cp_req.valid && cp_req.priv && hit_instr && !cp_req.write
        |=> cp_rdata[5:2] == 4'h5)
        else $error("instruction size field not 5h");

    a_data_size: assert property (@(posedge clk_sys) disable iff (rst) // [R11]
        state == ST_IDLE && cp_req.valid && cp_req.priv && hit_data && !cp_req.write
        |=> cp_rdata[5:2] == 4'h6)
        else $error("data size field not 6h");

    a_enable_write: assert property (@(posedge clk_sys) disable iff (rst) // [R08]
        state == ST_IDLE && cp_req.valid && cp_req.priv && cp_req.write && hit_data
        |=> ##1 data_region_enable == $past(cp_req.wdata[0], 2))
        else $error("data enable did not follow write");

    a_base_shift: assert property (@(posedge clk_sys) disable iff (rst) // [R05]
        state == ST_IDLE && cp_req.valid && cp_req.priv && cp_req.write && hit_instr
        |=> ##1 instr_local_mem_base == {$past(cp_req.wdata[31:12], 2), 12'h000})
        else $error("instruction base not field shifted by 12");

    a_user_refused: assert property (@(posedge clk_sys) disable iff (rst) // [R13]
        state == ST_IDLE && cp_req.valid && !cp_req.priv
        |=> cp_undef && !cp_ack && $stable(data_region_enable)
            && $stable(instr_region_enable))
        else $error("unprivileged transfer was accepted");

    a_reset_disabled: assert property (@(posedge clk_sys) // [R14]
        $past(rst) |-> !data_en && !instr_en)
        else $error("enable set after reset");

    a_disabled_nosel: assert property (@(posedge clk_sys) disable iff (rst) // [R15]
        !data_en |=> data_side_local_mem_sel == '0)
        else $error("disabled data memory selected a bank");

    a_answer_once: assert property (@(posedge clk_sys) disable iff (rst) // [R04]
        cp_ack || cp_undef |=> !cp_ack && !cp_undef)
        else $error("answer held longer than one cycle");

    a_size_legal: assert property (@(posedge clk_sys) disable iff (rst) // [R07]
        cp_ack |-> cp_rdata[5:2] == `LMR_SIZE_ABSENT
            || (cp_rdata[5:2] >= `LMR_SIZE_4K && cp_rdata[5:2] <= `LMR_SIZE_1M))
        else $error("size field holds a reserved code");

    a_data_base: assert property (@(posedge clk_sys) disable iff (rst) // [R05]
        state == ST_IDLE && cp_req.valid && cp_req.priv && cp_req.write && hit_data
        |=> ##1 data_local_mem_base == {$past(cp_req.wdata[31:12], 2), 12'h000})
        else $error("data base not field shifted by 12");

    a_instr_enable: assert property (@(posedge clk_sys) disable iff (rst) // [R08]
        state == ST_IDLE && cp_req.valid && cp_req.priv && cp_req.write && hit_instr
        |=> ##1 instr_region_enable == $past(cp_req.wdata[0], 2))
        else $error("instruction enable did not follow write");

endmodule : local_memory_region_control

// ---- bench/cp_core_model.sv ----
// Purpose: core-side model issuing coprocessor register transfers
// Assumes: one transfer at a time, answer expected within eight cycles
// Notes:   request held until ack or undef is sampled high at an edge
`include "lmr_regs.svh"
module cp_core_model
    import lmr_pkg::*;
(
    // Clock
    input  wire logic        clk_sys,
    // Transfer port
    output cp_req_t          cp_req,
    input  wire logic [31:0] cp_rdata,
    input  wire logic        cp_ack,
    input  wire logic        cp_undef
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cp_req = '0;

    ////////////////////////////////////////////////////////////////////////////
    // Resp is {undef, ack}; zero means no answer came
    task automatic xfer(
        input  logic        wr,
        input  logic        priv,
        input  logic [3:0]  crn,
        input  logic [3:0]  crm,
        input  logic [2:0]  op2,
        input  logic [31:0] wdata,
        output logic [31:0] rdata,
        output logic [1:0]  resp
    );
        cp_req_t req;
        req = '{1'b1, wr, priv, `LMR_OP1_SYS, crn, crm, op2, wdata};
        resp = 2'h0;
        rdata = 32'h0;
        @(posedge clk_sys);
        cp_req <= req;
        for (int n = 0; n < 8 && resp === 2'h0; n++)
        begin
            @(posedge clk_sys);
            resp = {cp_undef, cp_ack};
            rdata = cp_rdata;
        end
        // Released lines carry inverted data so stale values cannot pass
        req.valid = 1'b0;
        req.wdata = ~wdata;
        cp_req <= req;
    endtask : xfer
endmodule : cp_core_model

// ---- bench/testbench.sv ----
// Purpose: self-checking bench for the local memory region control block
// Assumes: core model drives requests on the coprocessor port, bench drives access ports
// Notes:   no random stimulus; decode checked one cycle after each address
`include "lmr_regs.svh"
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module testbench
    import lmr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [3:0] C0 = `LMR_CRN_PRESENCE;
    localparam logic [3:0] C9 = `LMR_CRN_REGION;
    localparam logic [3:0] C1 = `LMR_CRM_REGION;

    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    cp_req_t     cp_req;
    logic [31:0] cp_rdata;
    logic        cp_ack;
    logic        cp_undef;
    logic        instr_acc_valid = 1'b0;
    logic [31:0] instr_acc_addr = 32'h0;
    logic        data_acc_valid = 1'b0;
    logic [31:0] data_acc_addr = 32'h0;
    bank_sel_t   instr_sel;
    bank_sel_t   data_sel;
    logic        instr_en;
    logic        data_en;
    logic [31:0] instr_base;
    logic [31:0] data_base;
    int          err_total = 0;
    int          checks = 0;

    always #4 clk_sys = ~clk_sys;

    local_memory_region_control local_memory_region_control_inst (
        .clk_sys                  (clk_sys),
        .rst                      (rst),
        .cp_req                   (cp_req),
        .cp_rdata                 (cp_rdata),
        .cp_ack                   (cp_ack),
        .cp_undef                 (cp_undef),
        .instr_acc_valid          (instr_acc_valid),
        .instr_acc_addr           (instr_acc_addr),
        .instr_side_local_mem_sel (instr_sel),
        .data_acc_valid           (data_acc_valid),
        .data_acc_addr            (data_acc_addr),
        .data_side_local_mem_sel  (data_sel),
        .instr_region_enable      (instr_en),
        .data_region_enable       (data_en),
        .instr_local_mem_base     (instr_base),
        .data_local_mem_base      (data_base)
    );

    cp_core_model cp_core_model_inst (
        .clk_sys  (clk_sys),
        .cp_req   (cp_req),
        .cp_rdata (cp_rdata),
        .cp_ack   (cp_ack),
        .cp_undef (cp_undef)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Checks %0d, errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // Expected response 1 is ack, 2 is undef; read data only checked on reads
    task automatic acc(input logic wr, input logic priv, input logic [3:0] crn,
                       input logic [3:0] crm, input logic [2:0] op2, input logic [31:0] wd,
                       input logic [1:0] exp_resp, input logic [31:0] exp_rd);
        logic [31:0] rd;
        logic [1:0]  resp;
        cp_core_model_inst.xfer(wr, priv, crn, crm, op2, wd, rd, resp);
        `CHK(resp, exp_resp)
        if (!wr)
            `CHK(rd, exp_rd)
    endtask : acc

    // Side 0 drives the instruction port, side 1 the data port
    task automatic dec(input logic side, input logic v, input logic [31:0] a,
                       input bank_sel_t e);
        @(posedge clk_sys);
        instr_acc_valid <= v & ~side;
        instr_acc_addr <= a;
        data_acc_valid <= v & side;
        data_acc_addr <= a;
        @(posedge clk_sys);
        #1;
        `CHK(side ? data_sel : instr_sel, e)
        `CHK(side ? instr_sel : data_sel, 3'h0)
    endtask : dec

    task automatic reset_pulse();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : reset_pulse

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] ta [12] = '{32'h0, 32'h1FFC, 32'h2000, 32'h5FFC, 32'h6000, 32'h8000,
                             32'h8000, 32'hA004, 32'hDFFC, 32'hE000, 32'h0, 32'h10000};
    logic        ts [12] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0,
                             1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1};
    logic [2:0]  te [12] = '{3'h4, 3'h4, 3'h2, 3'h1, 3'h0, 3'h0,
                             3'h4, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0};

    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK({instr_en, data_en, instr_base, data_base}, 66'h0)
        dec(1'h0, 1'h1, 32'h0, 3'h0);
        acc(1'h0, 1'h1, C0, C0, 3'h2, 32'h0, 2'h1, 32'h00010001);
        acc(1'h1, 1'h1, C0, C0, 3'h2, 32'hFFFFFFFF, 2'h2, 32'h0);
        acc(1'h0, 1'h0, C9, C1, 3'h0, 32'h0, 2'h2, 32'h0);
        acc(1'h0, 1'h1, C9, C1, 3'h3, 32'h0, 2'h2, 32'h0);
        acc(1'h0, 1'h1, C9, C1, 3'h0, 32'h0, 2'h1, 32'h18);
        acc(1'h0, 1'h1, C9, C1, 3'h1, 32'h0, 2'h1, 32'h14);
        acc(1'h1, 1'h1, C9, C1, 3'h1, 32'h00000FFF, 2'h1, 32'h0);
        acc(1'h0, 1'h1, C9, C1, 3'h1, 32'h0, 2'h1, 32'h15);
        acc(1'h1, 1'h1, C9, C1, 3'h0, 32'h00008FFE, 2'h1, 32'h0);
        acc(1'h0, 1'h1, C9, C1, 3'h0, 32'h0, 2'h1, 32'h8018);
        `CHK({data_en, data_base}, 33'h0_00008000)
        acc(1'h1, 1'h1, C9, C1, 3'h0, 32'h00008001, 2'h1, 32'h0);
        acc(1'h1, 1'h0, C9, C1, 3'h0, 32'h0, 2'h2, 32'h0);
        `CHK({instr_en, data_en}, 2'h3)
        for (int i = 0; i < 12; i++)
            dec(ts[i], 1'h1, ta[i], te[i]);
        dec(1'h0, 1'h0, 32'h2000, 3'h0);
        reset_pulse();
        `CHK({instr_en, data_en, instr_base, data_base}, 66'h0)
        dec(1'h1, 1'h1, 32'h8000, 3'h0);
        acc(1'h0, 1'h1, C9, C1, 3'h1, 32'h0, 2'h1, 32'h14);
        conclude();
    end

    initial
    begin
        repeat (3000) @(posedge clk_sys);
        err_total++;
        conclude();
    end
endmodule : testbench
